// ### hw/ras_record_pkg.sv
package ras_record_pkg;

    // Data widths of the register path
    localparam int DATA_W    = 32;
    localparam int CODE_W    = 5;
    localparam int SEL_W     = 16;

    // Register reset values
    localparam logic [31:0] FEATURES_RESET = 32'hC0000062;
    localparam logic [31:0] STATUS_RESET   = 32'h00000000;

    // Record selected by the record select field for this record
    localparam logic [SEL_W-1:0] RECORD_INDEX = 16'h0000;

    // Feature register field positions
    localparam int FEAT_RESTART_BIT = 30;
    localparam int FEAT_CE_HI       = 7;
    localparam int FEAT_CE_LO       = 6;
    localparam int FEAT_DE_BIT      = 5;
    localparam int FEAT_UER_BIT     = 3;
    localparam int FEAT_UEU_BIT     = 2;
    localparam int FEAT_UC_BIT      = 1;
    localparam int FEAT_OF_BIT      = 0;

    // Status register field positions
    localparam int ST_AV_BIT   = 31;
    localparam int ST_V_BIT    = 30;
    localparam int ST_UE_BIT   = 29;
    localparam int ST_ER_BIT   = 28;
    localparam int ST_OF_BIT   = 27;
    localparam int ST_MV_BIT   = 26;
    localparam int ST_CE_HI    = 25;
    localparam int ST_CE_LO    = 24;
    localparam int ST_DE_BIT   = 23;
    localparam int ST_PN_BIT   = 22;
    localparam int ST_UET_HI   = 21;
    localparam int ST_UET_LO   = 20;
    localparam int ST_CODE_HI  = 4;
    localparam int ST_CODE_LO  = 0;

    // Constant field values
    localparam logic [1:0] CE_RECORDED    = 2'h2;
    localparam logic [1:0] CE_NONE        = 2'h0;
    localparam logic [1:0] UET_UNCONTAIN  = 2'h0;

    // Primary error codes
    localparam logic [CODE_W-1:0] CODE_NONE      = 5'h00;
    localparam logic [CODE_W-1:0] CODE_INJECT    = 5'h01;
    localparam logic [CODE_W-1:0] CODE_BUF_ECC   = 5'h02;
    localparam logic [CODE_W-1:0] CODE_DATA_ECC  = 5'h06;
    localparam logic [CODE_W-1:0] CODE_TAG_ECC   = 5'h07;
    localparam logic [CODE_W-1:0] CODE_TLB_PAR   = 5'h08;
    localparam logic [CODE_W-1:0] CODE_COPYBACK  = 5'h12;
    localparam logic [CODE_W-1:0] CODE_DEFER_SLV = 5'h15;

    // Which selected-record alias an access names
    typedef enum logic [1:0] {
        ALIAS_FEATURES = 2'h0,
        ALIAS_STATUS   = 2'h1,
        ALIAS_OTHER    = 2'h2
    } alias_t;

    // One system register access
    typedef struct packed {
        logic              valid;
        logic              write;
        alias_t            alias_sel;
        logic [DATA_W-1:0] wdata;
    } sysreg_req_t;

    // Answer to one access
    typedef struct packed {
        logic              valid;
        logic              error;
        logic [DATA_W-1:0] rdata;
    } sysreg_rsp_t;

    // One detected error offered to the record
    typedef struct packed {
        logic              valid;
        logic              injected;
        logic [CODE_W-1:0] code;
        logic              uncorrected;
        logic              deferred;
        logic              corrected;
        logic              reported;
        logic              addr_valid;
        logic              misc_valid;
    } err_event_t;

endpackage

// ### hw/ras_error_record_status.sv
`timescale 1ns/1ps
module ras_error_record_status (
    input  wire logic                                  clk,
    input  wire logic                                  reset_n,
    input  wire logic [ras_record_pkg::SEL_W-1:0]      record_select_field,
    input  wire ras_record_pkg::sysreg_req_t           req,
    output ras_record_pkg::sysreg_rsp_t                rsp,
    input  wire ras_record_pkg::err_event_t            err_event,
    input  wire logic                                  recovery_irq_enable,
    output logic                                       recovery_irq,
    output logic                                       address_capture
);
    import ras_record_pkg::*;

    // Live status state; constant fields are never stored
    logic              address_valid_flag;
    logic              status_valid;
    logic              uncorrected_flag;
    logic              abort_reported_flag;
    logic              overflow_flag;
    logic              extra_info_valid_flag;
    logic              corrected_seen;
    logic              deferred_flag;
    logic [CODE_W-1:0] primary_code_field;

    // Clear strobes from a write-one-to-clear access
    logic              selected;
    logic              status_write;
    logic [DATA_W-1:0] clear_mask;
    logic              keep_v;
    logic              keep_ue;
    logic              capture;

    // Decoded parts of the capture decision
    logic              record_empty;
    logic              outranks;

    // Next values, worked out before the clock edge that stores them
    logic              next_status_valid;
    logic              next_uncorrected;
    logic              next_abort_reported;
    logic              next_overflow;
    logic              next_corrected_seen;
    logic              next_deferred;
    logic              overflow_event;
    logic              next_address_capture;
    logic              next_recovery_irq;

    // Read answer built combinationally, then registered onto the port
    logic [DATA_W-1:0] next_rdata;
    logic              next_error;

    // Set-wins update shared by every sticky flag. An event that lands in
    // the same cycle as a software clear must not be lost, so the set term
    // is applied after the clear has been taken out.
    function automatic logic sticky_next(
        input logic set,
        input logic held,
        input logic clear
    );
        return set || (held && !clear);
    endfunction

    // Alias decode shared by the write-clear strobe and the read mux
    function automatic logic alias_is(
        input sysreg_req_t r,
        input alias_t      a
    );
        return r.alias_sel == a;
    endfunction

    // Assemble the status word from live state and constant fields
    function automatic logic [DATA_W-1:0] status_word(
        input logic              av,
        input logic              v,
        input logic              ue,
        input logic              er,
        input logic              of_f,
        input logic              mv,
        input logic              ce,
        input logic              de,
        input logic [CODE_W-1:0] code
    );
        logic [DATA_W-1:0] w;
        w = STATUS_RESET;
        w[ST_AV_BIT] = av;
        w[ST_V_BIT]  = v;
        w[ST_UE_BIT] = ue;
        w[ST_ER_BIT] = er;
        w[ST_OF_BIT] = of_f;
        w[ST_MV_BIT] = mv;
        w[ST_CE_HI:ST_CE_LO] = ce ? CE_RECORDED : CE_NONE;
        w[ST_DE_BIT] = de;
        w[ST_PN_BIT] = 1'b0;
        w[ST_UET_HI:ST_UET_LO] = UET_UNCONTAIN;
        w[ST_CODE_HI:ST_CODE_LO] = code;
        return w;
    endfunction

    // Decode of an access aimed at this record
    // record select gate
    assign selected     = req.valid && (record_select_field == RECORD_INDEX);
    assign status_write = selected && req.write && alias_is(req, ALIAS_STATUS);
    // Status writes are write-one-to-clear: each one bit in the data
    // clears the matching flag, zero bits leave it alone. Bits that read
    // as constants ignore the mask entirely.
    assign clear_mask   = status_write ? req.wdata : '0;

    // A flag being cleared this cycle no longer guards later errors, so
    // an error arriving with the clear is treated as landing in an empty
    // record and keeps its details
    assign keep_v  = status_valid && !clear_mask[ST_V_BIT];
    assign keep_ue = uncorrected_flag && !clear_mask[ST_UE_BIT];

    // Record is free for new details when empty or being emptied now
    assign record_empty = !keep_v;
    // Only an uncorrected error outranks what is held; corrected and
    // deferred errors never displace earlier details, only set overflow and the other sticky flags
    assign outranks     = err_event.uncorrected && !keep_ue;
    // Details are taken by an empty record, or by an error that outranks
    // the one already held
    assign capture      = err_event.valid && (record_empty || outranks);

    // Next values of the sticky flags; an error only ever sets them and
    // only a write-one-to-clear takes them down again
    // valid on any error
    assign next_status_valid   = sticky_next(err_event.valid, status_valid,
                                             clear_mask[ST_V_BIT]);
    assign next_uncorrected    = sticky_next(err_event.valid && err_event.uncorrected,
                                             uncorrected_flag, clear_mask[ST_UE_BIT]);
    assign next_abort_reported = sticky_next(err_event.valid && err_event.reported,
                                             abort_reported_flag, clear_mask[ST_ER_BIT]);
    assign next_corrected_seen = sticky_next(err_event.valid && err_event.corrected,
                                             corrected_seen, clear_mask[ST_CE_HI]);
    assign next_deferred       = sticky_next(err_event.valid && err_event.deferred,
                                             deferred_flag, clear_mask[ST_DE_BIT]);

    // Overflow marks that a second error found the record occupied
    // discarded details set overflow
    // injected errors take the same path
    assign overflow_event      = err_event.valid && keep_v;
    assign next_overflow       = sticky_next(overflow_event, overflow_flag,
                                             clear_mask[ST_OF_BIT]);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            status_valid <= 1'b0;
        end else begin
            status_valid <= next_status_valid;
        end
    end

    // Uncorrected flag; also the source of the recovery interrupt
    // uncorrected flag register
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            uncorrected_flag <= 1'b0;
        end else begin
            uncorrected_flag <= next_uncorrected;
        end
    end

    // Reported flag stays set until software writes one to clear it
    // reported flag register
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            abort_reported_flag <= 1'b0;
        end else begin
            abort_reported_flag <= next_abort_reported;
        end
    end

    // Corrected errors are only remembered, never counted here
    // corrected flag register
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            corrected_seen <= 1'b0;
        end else begin
            corrected_seen <= next_corrected_seen;
        end
    end

    // Deferred flag, independent of the uncorrected flag
    // deferred flag register
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            deferred_flag <= 1'b0;
        end else begin
            deferred_flag <= next_deferred;
        end
    end

    // Overflow is kept even when the record is emptied; software must
    // clear it on its own. Any second error counts, whatever its class,
    // which is coarser than tracking losses per class.
    // overflow register
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            overflow_flag <= 1'b0;
        end else begin
            overflow_flag <= next_overflow;
        end
    end

    // Details that belong to the highest-priority captured error. A
    // capture in the same cycle as a clear wins, like the sticky flags.
    // address valid with capture
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            address_valid_flag <= 1'b0;
        end else if (capture) begin
            address_valid_flag <= err_event.addr_valid;
        end else if (clear_mask[ST_AV_BIT]) begin
            address_valid_flag <= 1'b0;
        end
    end

    // Extra info follows the same capture as the address
    // extra info valid
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            extra_info_valid_flag <= 1'b0;
        end else if (capture) begin
            extra_info_valid_flag <= err_event.misc_valid;
        end else if (clear_mask[ST_MV_BIT]) begin
            extra_info_valid_flag <= 1'b0;
        end
    end

    // Code is meaningless once the record is emptied, so clearing the
    // valid bit also returns it to the no-error code
    // injected errors report CODE_INJECT in place of their own code
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            primary_code_field <= CODE_NONE;
        end else if (capture) begin
            primary_code_field <= err_event.injected ? CODE_INJECT : err_event.code;
        end else if (clear_mask[ST_V_BIT]) begin
            primary_code_field <= CODE_NONE;
        end
    end

    // Strobe telling the address register to load with this capture.
    // The address register itself lives outside this block, so it sees
    // the strobe one cycle after the error.
    // address load strobe
    assign next_address_capture = capture && err_event.addr_valid;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            address_capture <= 1'b0;
        end else begin
            address_capture <= next_address_capture;
        end
    end

    // Interrupt follows the uncorrected flag, registered for a clean output.
    // It lags the flag by one cycle, so software may see the flag first.
    // interrupt held until cleared
    assign next_recovery_irq = recovery_irq_enable && uncorrected_flag;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            recovery_irq <= 1'b0;
        end else begin
            recovery_irq <= next_recovery_irq;
        end
    end

    // Read mux. The read shows state before any clear carried by the
    // same access, because it is taken from the registers, not next values.
    // A write gets a zero word back; its effect shows on the next read.
    always_comb begin
        next_rdata = '0;
        next_error = 1'b0;
        if (!selected) begin
            // Other record or idle: read zero, no error
            next_error = 1'b0;
        end else if (alias_is(req, ALIAS_FEATURES)) begin
            // CE and DE bits in constant
            next_rdata = req.write ? '0 : FEATURES_RESET;
        end else if (alias_is(req, ALIAS_STATUS)) begin
            if (!req.write) begin
                next_rdata = status_word(address_valid_flag, status_valid, uncorrected_flag,
                                         abort_reported_flag, overflow_flag,
                                         extra_info_valid_flag, corrected_seen,
                                         deferred_flag, primary_code_field);
            end
        end else begin
            // Unmapped alias refused
            next_error = 1'b1;
        end
    end

    // Answer register; every access is answered exactly one cycle later,
    // so the requester never has to poll for the result
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rsp <= '0;
        end else begin
            rsp.valid <= req.valid;
            rsp.error <= next_error;
            rsp.rdata <= next_rdata;
        end
    end

endmodule

// ### verification/ras_error_record_status_sva.sv
`timescale 1ns/1ps
module ras_error_record_status_chk
    import ras_record_pkg::*;
(
    input wire logic                             clk,
    input wire logic                             reset_n,
    input wire logic [ras_record_pkg::SEL_W-1:0] record_select_field,
    input wire ras_record_pkg::sysreg_req_t      req,
    input wire ras_record_pkg::sysreg_rsp_t      rsp,
    input wire ras_record_pkg::err_event_t       err_event,
    input wire logic                             recovery_irq_enable,
    input wire logic                             recovery_irq,
    input wire logic                             address_capture
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // Read aimed at this record
    wire logic hit = req.valid && !req.write && record_select_field == RECORD_INDEX;

    property p_answer; req.valid |=> rsp.valid; endproperty
    a_answer: assert property (p_answer) else $error("access not answered");
    property p_feat; hit && req.alias_sel == ALIAS_FEATURES |=> rsp.rdata == FEATURES_RESET; endproperty
    a_feat: assert property (p_feat) else $error("features value wrong");
    property p_desel; req.valid && record_select_field != RECORD_INDEX |=> rsp.rdata == 32'h0; endproperty
    a_desel: assert property (p_desel) else $error("deselected record answered");
    property p_other; req.valid && record_select_field == RECORD_INDEX
        && req.alias_sel == ALIAS_OTHER |=> rsp.error; endproperty
    a_other: assert property (p_other) else $error("unmapped alias not refused");
    property p_resv; hit && req.alias_sel == ALIAS_STATUS |=> rsp.rdata[22:5] == 18'h0; endproperty
    a_resv: assert property (p_resv) else $error("reserved status bits set");
    property p_cap; address_capture |-> $past(err_event.valid) && $past(err_event.addr_valid); endproperty
    a_cap: assert property (p_cap) else $error("address capture without cause");
    property p_irq_off; recovery_irq |-> $past(recovery_irq_enable); endproperty
    a_irq_off: assert property (p_irq_off) else $error("interrupt while disabled");
    property p_irq_on; err_event.valid && err_event.uncorrected && recovery_irq_enable
        ##1 recovery_irq_enable |=> recovery_irq; endproperty
    a_irq_on: assert property (p_irq_on) else $error("interrupt not raised");
    property p_valid; err_event.valid ##1 (!req.valid)[*2] ##1 (hit
        && req.alias_sel == ALIAS_STATUS) |=> rsp.rdata[30]; endproperty
    a_valid: assert property (p_valid) else $error("status valid missing");
endmodule

bind ras_error_record_status ras_error_record_status_chk chk (
    .clk(clk), .reset_n(reset_n), .record_select_field(record_select_field), .req(req),
    .rsp(rsp), .err_event(err_event), .recovery_irq_enable(recovery_irq_enable),
    .recovery_irq(recovery_irq), .address_capture(address_capture));

// ### verification/test_ras_error_record_status.sv
`timescale 1ns/1ps
module test_ras_error_record_status;
    import ras_record_pkg::*;
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic [15:0] record_select_field = 16'h0000;
    sysreg_req_t req = '0;
    sysreg_rsp_t rsp;
    err_event_t  err_event = '0;
    logic        recovery_irq_enable = 1'b0;
    logic        recovery_irq;
    logic        address_capture;
    int          failures = 0;
    int          tests_run = 0;
    logic [31:0] rd;
    logic        er;
    logic        ue1;
    err_event_t  ev;
    logic [4:0]  codes [8] = '{5'h00, 5'h01, 5'h02, 5'h06, 5'h07, 5'h08, 5'h12, 5'h15};

    ras_error_record_status dut (
        .clk(clk), .reset_n(reset_n), .record_select_field(record_select_field), .req(req),
        .rsp(rsp), .err_event(err_event), .recovery_irq_enable(recovery_irq_enable),
        .recovery_irq(recovery_irq), .address_capture(address_capture));

    always #4 clk = ~clk;

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // One access; the answer stands in the cycle after the request
    task automatic access(input logic w, input alias_t a, input logic [31:0] d,
                          input logic [15:0] s);
        @(posedge clk);
        record_select_field <= s;
        req <= '{valid: 1'b1, write: w, alias_sel: a, wdata: d};
        @(posedge clk);
        req.valid <= 1'b0;
        #1;
        check("answer valid", {31'h0, rsp.valid}, 32'h1);
        rd = rsp.rdata;
        er = rsp.error;
    endtask

    // Offer one error, then look at capture pulse and interrupt level
    task automatic fire(input err_event_t e, input logic ue_prev);
        @(posedge clk);
        err_event <= e;
        @(posedge clk);
        err_event.valid <= 1'b0;
        #1;
        check("address capture", {31'h0, address_capture}, {31'h0, e.addr_valid});
        @(posedge clk);
        #1;
        check("irq", {31'h0, recovery_irq}, {31'h0, recovery_irq_enable & (e.uncorrected | ue_prev)});
    endtask

    // Status of a record that was empty when the error arrived
    function automatic logic [31:0] exp_status(input err_event_t e);
        logic [31:0] s;
        s = 32'h0;
        s[ST_AV_BIT] = e.addr_valid;
        s[ST_V_BIT] = 1'b1;
        s[ST_UE_BIT] = e.uncorrected;
        s[ST_ER_BIT] = e.reported;
        s[ST_MV_BIT] = e.misc_valid;
        s[ST_CE_HI:ST_CE_LO] = e.corrected ? CE_RECORDED : CE_NONE;
        s[ST_DE_BIT] = e.deferred;
        s[ST_CODE_HI:ST_CODE_LO] = e.injected ? CODE_INJECT : e.code;
        return s;
    endfunction

    // Cuts a hang short; the full run needs about 130 cycles
    initial begin
        #40000;
        failures++;
        tally_and_finish();
    end

    initial begin
        void'($urandom(92));
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        access(1'b0, ALIAS_STATUS, 32'h0, 16'h0);
        check("status reset", rd, STATUS_RESET);
        access(1'b0, ALIAS_FEATURES, 32'h0, 16'h0);
        check("features", rd, FEATURES_RESET);
        access(1'b1, ALIAS_FEATURES, $urandom, 16'h0);
        access(1'b0, ALIAS_FEATURES, 32'h0, 16'h0);
        check("features after write", rd, FEATURES_RESET);
        access(1'b0, ALIAS_OTHER, 32'h0, 16'h0);
        check("unmapped error", {31'h0, er}, 32'h1);
        access(1'b0, ALIAS_STATUS, 32'h0, 16'h0001 + 16'($urandom_range(0, 65534)));
        check("deselected", rd, 32'h0);
        // Every primary code on a fresh record, then a second error on top
        for (int i = 0; i < 8; i++) begin
            ev = err_event_t'($bits(err_event_t)'($urandom));
            ev.valid = 1'b1;
            ev.injected = (i == 1);
            ev.code = codes[i];
            ue1 = ev.uncorrected;
            @(posedge clk);
            recovery_irq_enable <= 1'($urandom);
            access(1'b1, ALIAS_STATUS, 32'hFFFFFFFF, 16'h0);
            fire(ev, 1'b0);
            access(1'b0, ALIAS_STATUS, 32'h0, 16'h0);
            check("status", rd, exp_status(ev));
            ev = err_event_t'($bits(err_event_t)'($urandom));
            ev.valid = 1'b1;
            ev.injected = 1'b1;
            ev.addr_valid = 1'b0;
            fire(ev, ue1);
            access(1'b0, ALIAS_STATUS, 32'h0, 16'h0);
            check("overflow", {30'h0, rd[30], rd[27]}, 32'h3);
        end
        // A write to another record must leave this one untouched
        access(1'b1, ALIAS_STATUS, 32'hFFFFFFFF, 16'h0001 + 16'($urandom_range(0, 65534)));
        access(1'b0, ALIAS_STATUS, 32'h0, 16'h0);
        check("deselected write", {30'h0, rd[30], rd[27]}, 32'h3);
        @(posedge clk);
        recovery_irq_enable <= 1'b1;
        access(1'b1, ALIAS_STATUS, 32'hFFFFFFFF, 16'h0);
        access(1'b0, ALIAS_STATUS, 32'h0, 16'h0);
        check("cleared", rd, 32'h0);
        check("irq cleared", {31'h0, recovery_irq}, 32'h0);
        tally_and_finish();
    end
endmodule
